// file: pkg/ltr_map.svh
`ifndef LTR_MAP_SVH
`define LTR_MAP_SVH
// ==========================================
// Register offsets, 8-bit APB address
`define LTR_TX_BASE 8'h00
`define LTR_RX_BASE 8'h10
`define LTR_OFS_CTRL 4'h0
`define LTR_OFS_BYTE0 4'h4
`define LTR_OFS_BYTE1 4'h5
`define LTR_OFS_BYTE2 4'h6
`define LTR_OFS_BYTE3 4'h7
// ==========================================
// Control bit positions
`define LTR_BIT_RESET 7
`define LTR_BIT_ENABLE 6
`define LTR_BIT_IRQ_EN 5
`define LTR_BIT_BYPASS 4
`define LTR_BIT_LOCK 3
`define LTR_BIT_RESTART 1
`define LTR_BIT_READY 0
// ==========================================
// Reset values and counts
`define LTR_CTRL_RST 8'h00
`define LTR_MATCH_FRAMES 2'h3
`endif

// file: pkg/ltr_pkg.sv
package ltr_pkg;
	// Training page, low half is the status report field
	typedef struct packed {
		logic [15:0] coef_update;
		logic [15:0] status_report;
	} ltr_page_type;

	// APB request carrier
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ltr_apb_req_type;

	typedef enum logic [1:0] {
		LTR_TX_IDLE = 2'b01,
		LTR_TX_COPY = 2'b10
	} ltr_tx_state_type;

	typedef enum logic [1:0] {
		LTR_RX_HUNT = 2'b01,
		LTR_RX_HELD = 2'b10
	} ltr_rx_state_type;
endpackage : ltr_pkg

// file: core/ltr_tx_plane.sv
`timescale 1ns/1ns
`default_nettype none
`include "ltr_map.svh"
module ltr_tx_plane
	import ltr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic plane_reset_in,
	input wire logic enable_in,
	input wire logic bypass_in,
	input wire logic page_ready_in,
	input wire ltr_page_type page_in,
	output logic page_taken_out,
	output ltr_page_type mdi_page_out,
	output logic mdi_drive_out
);
	ltr_tx_state_type state;
	ltr_tx_state_type next_state;
	ltr_page_type next_mdi_page;
	logic next_drive;

	// ==========================================
	// Page copy and MDI ownership
	always_comb
	begin
		next_state = state;
		next_mdi_page = mdi_page_out;
		next_drive = enable_in && !bypass_in;
		unique case (state)
			LTR_TX_IDLE:
			begin
				if (page_ready_in)
				begin
					next_mdi_page = page_in;
					next_state = LTR_TX_COPY;
				end
			end
			LTR_TX_COPY:
			begin
				next_state = LTR_TX_IDLE;
			end
		endcase
		if (plane_reset_in)
		begin
			next_state = LTR_TX_IDLE;
			next_mdi_page = mdi_page_out;
			next_drive = 1'b0;
		end
	end

	assign page_taken_out = (state == LTR_TX_COPY);

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state <= LTR_TX_IDLE;
			mdi_page_out <= '0;
			mdi_drive_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			mdi_page_out <= next_mdi_page;
			mdi_drive_out <= next_drive;
		end
	end
endmodule : ltr_tx_plane
`default_nettype wire

// file: core/ltr_rx_plane.sv
`timescale 1ns/1ns
`default_nettype none
`include "ltr_map.svh"
module ltr_rx_plane
	import ltr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic plane_reset_in,
	input wire logic hold_in,
	input wire logic restart_in,
	input wire logic frame_valid_in,
	input wire logic frame_err_in,
	input wire ltr_page_type frame_page_in,
	output logic lock_out,
	output logic capture_out,
	output ltr_page_type page_out
);
	ltr_rx_state_type state;
	ltr_rx_state_type next_state;
	ltr_page_type last_page;
	ltr_page_type next_last_page;
	ltr_page_type next_page;
	logic [1:0] match_cnt;
	logic [1:0] next_match_cnt;
	logic next_lock;
	logic next_capture;

	// ==========================================
	// Matching engine
	always_comb
	begin
		next_state = state;
		next_last_page = last_page;
		next_page = page_out;
		next_match_cnt = match_cnt;
		next_lock = lock_out;
		next_capture = 1'b0;
		if (frame_err_in)
		begin
			next_lock = 1'b0;
			next_match_cnt = 2'h0;
		end
		else if (frame_valid_in)
		begin
			next_lock = 1'b1;
			next_last_page = frame_page_in;
			if (match_cnt == 2'h0 || frame_page_in != last_page)
				next_match_cnt = 2'h1;
			else if (match_cnt != `LTR_MATCH_FRAMES)
				next_match_cnt = match_cnt + 2'h1;
		end
		unique case (state)
			LTR_RX_HUNT:
			begin
				if (next_match_cnt == `LTR_MATCH_FRAMES && frame_valid_in && !hold_in)
				begin
					next_page = frame_page_in;
					next_capture = 1'b1;
					next_state = LTR_RX_HELD;
				end
			end
			LTR_RX_HELD:
			begin
				if (restart_in)
				begin
					next_state = LTR_RX_HUNT;
					next_match_cnt = 2'h0;
				end
			end
		endcase
		if (plane_reset_in)
		begin
			next_state = LTR_RX_HUNT;
			next_match_cnt = 2'h0;
			next_lock = 1'b0;
			next_capture = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state <= LTR_RX_HUNT;
			last_page <= '0;
			page_out <= '0;
			match_cnt <= 2'h0;
			lock_out <= 1'b0;
			capture_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			last_page <= next_last_page;
			page_out <= next_page;
			match_cnt <= next_match_cnt;
			lock_out <= next_lock;
			capture_out <= next_capture;
		end
	end
endmodule : ltr_rx_plane
`default_nettype wire

// file: core/ltr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "ltr_map.svh"
module ltr_regs
	import ltr_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [7:0] pwdata_in,
	output logic [7:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic tx_bypass_in,
	output ltr_page_type tx_mdi_page_out,
	output logic tx_mdi_drive_out,
	input wire logic rx_frame_valid_in,
	input wire logic rx_frame_err_in,
	input wire ltr_page_type rx_frame_page_in,
	output logic irq_out
);
	ltr_apb_req_type req;
	logic [7:0] tx_ctrl;
	logic [7:0] rx_ctrl;
	logic [7:0] next_tx_ctrl;
	logic [7:0] next_rx_ctrl;
	ltr_page_type tx_page;
	ltr_page_type next_tx_page;
	logic [7:0] next_prdata;
	logic next_pslverr;
	logic bypass_meta;
	logic bypass_sync;
	logic wr_en;
	logic rd_setup;
	logic restart;
	logic tx_taken;
	logic rx_lock;
	logic rx_capture;
	ltr_page_type rx_page;

	// Address decode: offset within a bank, or no match
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] base, input logic [3:0] ofs);
		hit = (addr == (base | {4'h0, ofs}));
	endfunction : hit

	function automatic logic mapped(input logic [7:0] addr);
		logic [3:0] o;
		o = addr[3:0];
		mapped = (addr[7:4] == 4'(`LTR_TX_BASE >> 4) || addr[7:4] == 4'(`LTR_RX_BASE >> 4))
			&& (o == `LTR_OFS_CTRL || (o >= `LTR_OFS_BYTE0 && o <= `LTR_OFS_BYTE3));
	endfunction : mapped

	assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in, addr: paddr_in, wdata: pwdata_in};
	assign wr_en = req.sel && req.enable && req.write;
	assign rd_setup = req.sel && !req.enable && !req.write;
	assign pready_out = 1'b1;
	assign restart = wr_en && hit(req.addr, `LTR_RX_BASE, `LTR_OFS_CTRL) && req.wdata[`LTR_BIT_RESTART];
	assign irq_out = rx_ctrl[`LTR_BIT_IRQ_EN] && rx_ctrl[`LTR_BIT_READY];

	// ==========================================
	// Bypass pin synchroniser
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			bypass_meta <= 1'b0;
			bypass_sync <= 1'b0;
		end
		else
		begin
			bypass_meta <= tx_bypass_in;
			bypass_sync <= bypass_meta;
		end
	end

	// ==========================================
	// Register writes and hardware updates
	always_comb
	begin
		next_tx_ctrl = tx_ctrl;
		next_rx_ctrl = rx_ctrl;
		next_tx_page = tx_page;
		if (tx_taken)
			next_tx_ctrl[`LTR_BIT_READY] = 1'b0;
		if (wr_en && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_CTRL))
		begin
			next_tx_ctrl[`LTR_BIT_RESET] = req.wdata[`LTR_BIT_RESET];
			next_tx_ctrl[`LTR_BIT_ENABLE] = req.wdata[`LTR_BIT_ENABLE];
			if (req.wdata[`LTR_BIT_READY])
				next_tx_ctrl[`LTR_BIT_READY] = 1'b1;
		end
		if (wr_en && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE0))
			next_tx_page.status_report[7:0] = req.wdata;
		if (wr_en && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE1))
			next_tx_page.status_report[15:8] = req.wdata;
		if (wr_en && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE2))
			next_tx_page.coef_update[7:0] = req.wdata;
		if (wr_en && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE3))
			next_tx_page.coef_update[15:8] = req.wdata;
		if (wr_en && hit(req.addr, `LTR_RX_BASE, `LTR_OFS_CTRL))
		begin
			next_rx_ctrl[`LTR_BIT_RESET] = req.wdata[`LTR_BIT_RESET];
			next_rx_ctrl[`LTR_BIT_ENABLE] = req.wdata[`LTR_BIT_ENABLE];
			next_rx_ctrl[`LTR_BIT_IRQ_EN] = req.wdata[`LTR_BIT_IRQ_EN];
			if (req.wdata[`LTR_BIT_READY])
				next_rx_ctrl[`LTR_BIT_READY] = 1'b0;
		end
		if (rx_capture)
			next_rx_ctrl[`LTR_BIT_READY] = 1'b1;
	end

	// Read data registered in the setup phase
	always_comb
	begin
		next_prdata = prdata_out;
		next_pslverr = 1'b0;
		if (req.sel && !req.enable)
			next_pslverr = !mapped(req.addr);
		if (rd_setup)
		begin
			next_prdata = 8'h00;
			if (hit(req.addr, `LTR_TX_BASE, `LTR_OFS_CTRL))
			begin
				next_prdata = tx_ctrl;
				next_prdata[`LTR_BIT_BYPASS] = bypass_sync;
			end
			else if (hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE0))
				next_prdata = tx_page.status_report[7:0];
			else if (hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE1))
				next_prdata = tx_page.status_report[15:8];
			else if (hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE2))
				next_prdata = tx_page.coef_update[7:0];
			else if (hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE3))
				next_prdata = tx_page.coef_update[15:8];
			else if (hit(req.addr, `LTR_RX_BASE, `LTR_OFS_CTRL))
			begin
				next_prdata = rx_ctrl;
				next_prdata[`LTR_BIT_LOCK] = rx_lock;
			end
			else if (hit(req.addr, `LTR_RX_BASE, `LTR_OFS_BYTE0))
				next_prdata = rx_page.status_report[7:0];
			else if (hit(req.addr, `LTR_RX_BASE, `LTR_OFS_BYTE1))
				next_prdata = rx_page.status_report[15:8];
			else if (hit(req.addr, `LTR_RX_BASE, `LTR_OFS_BYTE2))
				next_prdata = rx_page.coef_update[7:0];
			else if (hit(req.addr, `LTR_RX_BASE, `LTR_OFS_BYTE3))
				next_prdata = rx_page.coef_update[15:8];
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			tx_ctrl <= `LTR_CTRL_RST;
			rx_ctrl <= `LTR_CTRL_RST;
			tx_page <= '0;
			prdata_out <= 8'h00;
			pslverr_out <= 1'b0;
		end
		else
		begin
			tx_ctrl <= next_tx_ctrl;
			rx_ctrl <= next_rx_ctrl;
			tx_page <= next_tx_page;
			prdata_out <= next_prdata;
			pslverr_out <= next_pslverr;
		end
	end

	// ==========================================
	// Dataplanes
	ltr_tx_plane u_tx_plane (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.plane_reset_in(tx_ctrl[`LTR_BIT_RESET]),
		.enable_in(tx_ctrl[`LTR_BIT_ENABLE]),
		.bypass_in(bypass_sync),
		.page_ready_in(tx_ctrl[`LTR_BIT_READY]),
		.page_in(tx_page),
		.page_taken_out(tx_taken),
		.mdi_page_out(tx_mdi_page_out),
		.mdi_drive_out(tx_mdi_drive_out)
	);

	ltr_rx_plane u_rx_plane (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.plane_reset_in(rx_ctrl[`LTR_BIT_RESET]),
		.hold_in(rx_ctrl[`LTR_BIT_READY]),
		.restart_in(restart),
		.frame_valid_in(rx_frame_valid_in),
		.frame_err_in(rx_frame_err_in),
		.frame_page_in(rx_frame_page_in),
		.lock_out(rx_lock),
		.capture_out(rx_capture),
		.page_out(rx_page)
	);

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	property p_tx_reset_quiet;
		tx_ctrl[`LTR_BIT_RESET] && $past(tx_ctrl[`LTR_BIT_RESET]) |-> !tx_mdi_drive_out && !tx_taken;
	endproperty
	a_tx_reset_quiet: assert property (p_tx_reset_quiet) else $error("tx plane active in reset");

	property p_apb_in_reset;
		rx_ctrl[`LTR_BIT_RESET] && wr_en && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_BYTE0)
			|=> tx_page.status_report[7:0] == $past(req.wdata);
	endproperty
	a_apb_in_reset: assert property (p_apb_in_reset) else $error("write lost during reset");

	property p_drive;
		tx_mdi_drive_out |-> $past(tx_ctrl[`LTR_BIT_ENABLE]) && !$past(bypass_sync);
	endproperty
	a_drive: assert property (p_drive) else $error("MDI driven without ownership");

	property p_bypass_read;
		rd_setup && hit(req.addr, `LTR_TX_BASE, `LTR_OFS_CTRL) |=> prdata_out[`LTR_BIT_BYPASS] == $past(bypass_sync);
	endproperty
	a_bypass_read: assert property (p_bypass_read) else $error("bypass readback wrong");

	property p_page_taken;
		tx_ctrl[`LTR_BIT_READY] && !tx_ctrl[`LTR_BIT_RESET] && !wr_en |-> ##[1:2] !tx_ctrl[`LTR_BIT_READY];
	endproperty
	a_page_taken: assert property (p_page_taken) else $error("tx page ready not cleared");

	property p_tx_copy;
		tx_taken |-> tx_mdi_page_out == $past(tx_page);
	endproperty
	a_tx_copy: assert property (p_tx_copy) else $error("tx page copy wrong");

	property p_rx_read;
		rd_setup && hit(req.addr, `LTR_RX_BASE, `LTR_OFS_BYTE3) |=> prdata_out == $past(rx_page.coef_update[15:8]);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("rx page readback wrong");

	property p_irq;
		$rose(rx_ctrl[`LTR_BIT_READY]) && rx_ctrl[`LTR_BIT_IRQ_EN] |-> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_irq_drop;
		wr_en && hit(req.addr, `LTR_RX_BASE, `LTR_OFS_CTRL) && req.wdata[`LTR_BIT_READY] && !rx_capture |=> !irq_out;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("interrupt not dropped");

	property p_rx_ctrl_read;
		rd_setup && hit(req.addr, `LTR_RX_BASE, `LTR_OFS_CTRL)
			|=> prdata_out[`LTR_BIT_LOCK] == $past(rx_lock) && !prdata_out[`LTR_BIT_RESTART];
	endproperty
	a_rx_ctrl_read: assert property (p_rx_ctrl_read) else $error("rx control readback wrong");

	property p_rx_hold;
		rx_ctrl[`LTR_BIT_READY] && $past(rx_ctrl[`LTR_BIT_READY]) |-> $stable(rx_page);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx page changed while pending");

	property p_tx_reset_page;
		tx_ctrl[`LTR_BIT_RESET] && $past(tx_ctrl[`LTR_BIT_RESET]) |-> $stable(tx_mdi_page_out);
	endproperty
	a_tx_reset_page: assert property (p_tx_reset_page) else $error("tx page copied in reset");

	property p_rx_reset_quiet;
		rx_ctrl[`LTR_BIT_RESET] && $past(rx_ctrl[`LTR_BIT_RESET]) |-> !rx_lock && !rx_capture;
	endproperty
	a_rx_reset_quiet: assert property (p_rx_reset_quiet) else $error("rx plane active in reset");

	property p_tx_taken_once;
		tx_taken |=> !tx_taken;
	endproperty
	a_tx_taken_once: assert property (p_tx_taken_once) else $error("tx page copied twice");

	property p_lock_drop;
		rx_frame_err_in |=> !rx_lock;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock kept after frame error");

	property p_pending_set;
		rx_capture |=> rx_ctrl[`LTR_BIT_READY];
	endproperty
	a_pending_set: assert property (p_pending_set) else $error("pending flag not set on capture");

	c_capture: cover property (rx_capture ##1 irq_out);
	c_tx_send: cover property (tx_ctrl[`LTR_BIT_READY] ##1 tx_taken ##1 tx_mdi_drive_out);
	c_restart: cover property (restart ##[1:20] rx_capture);
endmodule : ltr_regs
`default_nettype wire

// file: tb/ltr_link_partner.sv
`timescale 1ns/1ns
`default_nettype none
module ltr_link_partner
	import ltr_pkg::*;
(
	input wire logic ref_clk_in,
	output logic frame_valid_out,
	output logic frame_err_out,
	output ltr_page_type frame_page_out
);
	// ==========================================
	// Idle lines
	initial
	begin
		frame_valid_out = 1'b0;
		frame_err_out = 1'b0;
		frame_page_out = 32'h0000_0000;
	end

	// ==========================================
	// Training frames, one every four cycles
	task automatic send(input ltr_page_type page, input int count, input logic bad);
		for (int n = 0; n < count; n++)
		begin
			@(negedge ref_clk_in);
			frame_valid_out = !bad;
			frame_err_out = bad;
			frame_page_out = page;
			@(negedge ref_clk_in);
			frame_valid_out = 1'b0;
			frame_err_out = 1'b0;
			// Page lines not held between frames
			frame_page_out = ~page;
			repeat (2) @(negedge ref_clk_in);
		end
	endtask : send
endmodule : ltr_link_partner
`default_nettype wire

// file: tb/link_training_page_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module link_training_page_regs_test
	import ltr_pkg::*;
;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
		logic [7:0] exp;
		logic err;
	} ltr_row_type;

	logic ref_clk_in;
	logic reset_n_in;
	logic psel_in;
	logic penable_in;
	logic pwrite_in;
	logic [7:0] paddr_in;
	logic [7:0] pwdata_in;
	logic [7:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic tx_bypass_in;
	ltr_page_type tx_mdi_page_out;
	logic tx_mdi_drive_out;
	logic rx_frame_valid_in;
	logic rx_frame_err_in;
	ltr_page_type rx_frame_page_in;
	logic irq_out;
	logic [7:0] rdv;
	logic errv;
	int failures = 0;
	int checks = 0;

	ltr_row_type rows [19] = '{
		'{1'b0, 8'h00, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h10, 8'h00, 8'h00, 1'b0},
		'{1'b0, 8'h14, 8'h00, 8'h00, 1'b0},
		'{1'b1, 8'h04, 8'hA5, 8'h00, 1'b0},
		'{1'b1, 8'h05, 8'h5A, 8'h00, 1'b0},
		'{1'b1, 8'h06, 8'hC3, 8'h00, 1'b0},
		'{1'b1, 8'h07, 8'h3C, 8'h00, 1'b0},
		'{1'b0, 8'h04, 8'h00, 8'hA5, 1'b0},
		'{1'b0, 8'h05, 8'h00, 8'h5A, 1'b0},
		'{1'b0, 8'h06, 8'h00, 8'hC3, 1'b0},
		'{1'b0, 8'h07, 8'h00, 8'h3C, 1'b0},
		'{1'b1, 8'h14, 8'hFF, 8'h00, 1'b0},
		'{1'b0, 8'h14, 8'h00, 8'h00, 1'b0},
		'{1'b1, 8'h00, 8'h1E, 8'h00, 1'b0},
		'{1'b0, 8'h00, 8'h00, 8'h00, 1'b0},
		'{1'b1, 8'h10, 8'h76, 8'h00, 1'b0},
		'{1'b0, 8'h10, 8'h00, 8'h60, 1'b0},
		'{1'b1, 8'h08, 8'h11, 8'h00, 1'b1},
		'{1'b0, 8'h08, 8'h00, 8'h00, 1'b1}
	};

	ltr_regs i_dut (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.tx_bypass_in(tx_bypass_in),
		.tx_mdi_page_out(tx_mdi_page_out),
		.tx_mdi_drive_out(tx_mdi_drive_out),
		.rx_frame_valid_in(rx_frame_valid_in),
		.rx_frame_err_in(rx_frame_err_in),
		.rx_frame_page_in(rx_frame_page_in),
		.irq_out(irq_out)
	);

	ltr_link_partner i_partner (
		.ref_clk_in(ref_clk_in),
		.frame_valid_out(rx_frame_valid_in),
		.frame_err_out(rx_frame_err_in),
		.frame_page_out(rx_frame_page_in)
	);

	initial
	begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	// ==========================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// ==========================================
	// Register port cycles, setup then access
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		psel_in = 1'b1;
		pwrite_in = wr;
		paddr_in = a;
		pwdata_in = d;
		@(negedge ref_clk_in);
		penable_in = 1'b1;
		rdv = prdata_out;
		errv = pslverr_out;
		@(negedge ref_clk_in);
		psel_in = 1'b0;
		penable_in = 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		check(32'(rdv), 32'(exp));
	endtask : rd_chk

	initial
	begin
		#100000;
		failures++;
		print_verdict();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		reset_n_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h00;
		pwdata_in = 8'h00;
		tx_bypass_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		reset_n_in = 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].addr, rows[i].data);
			check(32'(errv), 32'(rows[i].err));
			if (!rows[i].wr)
				check(32'(rdv), 32'(rows[i].exp));
		end
		// Transmit page held back while plane in reset
		apb(1'b1, 8'h00, 8'hC1);
		repeat (4) @(negedge ref_clk_in);
		check(32'(tx_mdi_drive_out), 32'h0);
		check(tx_mdi_page_out, 32'h0000_0000);
		check(32'(pready_out), 32'h1);
		rd_chk(8'h00, 8'hC1);
		apb(1'b1, 8'h00, 8'h40);
		repeat (4) @(negedge ref_clk_in);
		rd_chk(8'h00, 8'h40);
		check(tx_mdi_page_out, 32'h3CC3_5AA5);
		check(32'(tx_mdi_drive_out), 32'h1);
		tx_bypass_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		check(32'(tx_mdi_drive_out), 32'h0);
		rd_chk(8'h00, 8'h50);
		tx_bypass_in = 1'b0;
		// Receive capture, freeze, clear, restart
		i_partner.send(32'h1234_5678, 3, 1'b0);
		repeat (3) @(negedge ref_clk_in);
		check(32'(irq_out), 32'h1);
		rd_chk(8'h10, 8'h69);
		for (int k = 0; k < 4; k++)
			rd_chk(8'(8'h14 + k), 8'(32'h1234_5678 >> (8 * k)));
		i_partner.send(32'hCAFE_F00D, 3, 1'b0);
		repeat (3) @(negedge ref_clk_in);
		rd_chk(8'h14, 8'h78);
		apb(1'b1, 8'h10, 8'h21);
		check(32'(irq_out), 32'h0);
		apb(1'b1, 8'h10, 8'h22);
		i_partner.send(32'hCAFE_F00D, 3, 1'b0);
		repeat (3) @(negedge ref_clk_in);
		rd_chk(8'h14, 8'h0D);
		rd_chk(8'h10, 8'h29);
		i_partner.send(32'hCAFE_F00D, 1, 1'b1);
		rd_chk(8'h10, 8'h21);
		// Receive plane reset blocks capture
		apb(1'b1, 8'h10, 8'hA1);
		i_partner.send(32'h1234_5678, 3, 1'b0);
		repeat (3) @(negedge ref_clk_in);
		rd_chk(8'h10, 8'hA0);
		check(32'(irq_out), 32'h0);
		// Second reset in mid-run
		reset_n_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
		reset_n_in = 1'b1;
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h10, 8'h00);
		check(32'(tx_mdi_drive_out), 32'h0);
		print_verdict();
	end
endmodule : link_training_page_regs_test
`default_nettype wire
